// ### logic/seerd_pkg.sv
// Package with shared constants of the serial EEPROM read path.
package seerd_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 1024;
    // Device-type code; value is arbitrary.
    localparam logic [3:0] DEV_CODE = 4'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    // Link clock divider: system clock cycles per bit phase (clock low one phase, high two).
    localparam int LINK_CLK_NS = 160;
    localparam int SYS_CLK_NS = 20;
    localparam int HALF_CYC = LINK_CLK_NS / SYS_CLK_NS / 2;
    // Programming cycle length, in system clocks.
    localparam int PROG_CYC = 64;
    // Host command codes.
    typedef enum logic [1:0] {
        SEERD_CMD_CUR = 2'h0,
        SEERD_CMD_RAND = 2'h1,
        SEERD_CMD_WRITE = 2'h2
    } seerd_cmd_t;
endpackage : seerd_pkg

// ### logic/seerd_if.sv
// Interface joining the two-wire master and the memory slave.
`timescale 1ns/1ps
interface seerd_if;
    // Clock driven by master only.
    logic scl;
    // Open-drain data: each end gives output and enable (low enable drives).
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    logic sda;
    // Wired-and line with pull-up.
    assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
    modport master (output scl, output sda_m_o, output sda_m_oe_n, input sda);
    modport slave (input scl, input sda, output sda_s_o, output sda_s_oe_n);
endinterface : seerd_if

// ### logic/seerd_slave.sv
// Memory slave end: two-wire protocol, address pointer, array.
`timescale 1ns/1ps
module seerd_slave (
    // System.
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Link.
    seerd_if.slave bus,
    // User side.
    input wire logic write_protect,
    output logic prog_busy,
    output logic [seerd_pkg::ADDR_W-1:0] addr_ptr
);
    typedef enum logic [2:0] {
        SEERD_S_IDLE = 3'b000,
        SEERD_S_CTRL = 3'b001,
        SEERD_S_CACK = 3'b011,
        SEERD_S_ADDR = 3'b010,
        SEERD_S_WDAT = 3'b110,
        SEERD_S_RDAT = 3'b111,
        SEERD_S_MACK = 3'b101,
        SEERD_S_WACK = 3'b100
    } seerd_sst_t;

    localparam int AW = seerd_pkg::ADDR_W;
    localparam int DW = seerd_pkg::DATA_W;

    // Array storage kept inside the slave.
    logic [DW-1:0] mem [seerd_pkg::MEM_DEPTH];

    // Pin synchronisers.
    logic [1:0] scl_s_r, sda_s_r;
    logic scl_d_r, sda_d_r;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (clk_en) begin
            scl_s_r <= {scl_s_r[0], bus.scl};
            sda_s_r <= {sda_s_r[0], bus.sda};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    // Edge and condition detection from synchronised levels only.
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s_r[1] & ~scl_d_r;
    assign scl_fall = ~scl_s_r[1] & scl_d_r;
    assign start_c = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
    assign stop_c = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

    // Wrapping pointer step; used for reads and writes.
    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
        next_addr = a + AW'(1);
    endfunction : next_addr

    seerd_sst_t st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [DW-1:0] sh_r, sh_nxt;
    logic [AW-1:0] ptr_r, ptr_nxt;
    logic rd_r, rd_nxt;
    logic oe_n_r, oe_n_nxt;
    logic wpend_r, wpend_nxt;
    logic [DW-1:0] wdat_r, wdat_nxt;
    logic [AW-1:0] waddr_r, waddr_nxt;
    logic [7:0] busy_r, busy_nxt;
    // Set by the first clock rise after a start; hides the clock fall that follows a start.
    logic seen_r, seen_nxt;
    logic do_wr;

    // Protocol next-state logic.
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        rd_nxt = rd_r;
        oe_n_nxt = oe_n_r;
        wpend_nxt = wpend_r;
        wdat_nxt = wdat_r;
        waddr_nxt = waddr_r;
        seen_nxt = seen_r;
        busy_nxt = (busy_r != 8'h00) ? busy_r - 8'h01 : busy_r;
        do_wr = 1'b0;
        if (start_c) begin
            // Repeated start abandons a write without programming.
            st_nxt = SEERD_S_CTRL;
            bit_nxt = seerd_pkg::BIT_LAST;
            oe_n_nxt = 1'b1;
            wpend_nxt = 1'b0;
            seen_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt = SEERD_S_IDLE;
            oe_n_nxt = 1'b1;
            if (wpend_r && !write_protect) begin
                do_wr = 1'b1;
                busy_nxt = 8'(seerd_pkg::PROG_CYC);
            end
            wpend_nxt = 1'b0;
        end else begin
            case (st_r)
                SEERD_S_IDLE: begin
                    oe_n_nxt = 1'b1;
                end
                SEERD_S_CTRL, SEERD_S_ADDR, SEERD_S_WDAT: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[DW-2:0], sda_s_r[1]};
                        seen_nxt = 1'b1;
                    end
                    if (scl_fall && seen_r) begin
                        if (bit_r == seerd_pkg::BIT_FIRST) begin
                            if (st_r == SEERD_S_CTRL) begin
                                // Code, ignored top select, block, read bit.
                                if (sh_r[7:4] == seerd_pkg::DEV_CODE && busy_r == 8'h00) begin
                                    oe_n_nxt = 1'b0;
                                    rd_nxt = sh_r[0];
                                    ptr_nxt = {sh_r[2:1], ptr_r[7:0]};
                                    st_nxt = SEERD_S_CACK;
                                end else begin
                                    st_nxt = SEERD_S_IDLE;
                                end
                            end else begin
                                oe_n_nxt = 1'b0;
                                if (st_r == SEERD_S_ADDR) begin
                                    ptr_nxt = {ptr_r[9:8], sh_r};
                                end else begin
                                    wdat_nxt = sh_r;
                                    waddr_nxt = ptr_r;
                                    wpend_nxt = 1'b1;
                                    ptr_nxt = next_addr(ptr_r);
                                end
                                st_nxt = SEERD_S_WACK;
                            end
                        end else begin
                            bit_nxt = bit_r - 3'h1;
                        end
                    end
                end
                SEERD_S_CACK: begin
                    if (scl_fall) begin
                        bit_nxt = seerd_pkg::BIT_LAST;
                        if (rd_r == seerd_pkg::RW_READ) begin
                            // Current pointer data goes out.
                            sh_nxt = mem[ptr_r];
                            oe_n_nxt = mem[ptr_r][DW-1];
                            st_nxt = SEERD_S_RDAT;
                        end else begin
                            oe_n_nxt = 1'b1;
                            st_nxt = SEERD_S_ADDR;
                        end
                    end
                end
                SEERD_S_WACK: begin
                    if (scl_fall) begin
                        oe_n_nxt = 1'b1;
                        bit_nxt = seerd_pkg::BIT_LAST;
                        st_nxt = SEERD_S_WDAT;
                    end
                end
                SEERD_S_RDAT: begin
                    if (scl_fall) begin
                        if (bit_r == seerd_pkg::BIT_FIRST) begin
                            oe_n_nxt = 1'b1;
                            ptr_nxt = next_addr(ptr_r);
                            st_nxt = SEERD_S_MACK;
                        end else begin
                            bit_nxt = bit_r - 3'h1;
                            sh_nxt = {sh_r[DW-2:0], 1'b0};
                            oe_n_nxt = sh_r[DW-2];
                        end
                    end
                end
                SEERD_S_MACK: begin
                    if (scl_rise) begin
                        // Low is a master acknowledge.
                        rd_nxt = ~sda_s_r[1];
                    end
                    if (scl_fall) begin
                        if (rd_r) begin
                            bit_nxt = seerd_pkg::BIT_LAST;
                            sh_nxt = mem[ptr_r];
                            oe_n_nxt = mem[ptr_r][DW-1];
                            st_nxt = SEERD_S_RDAT;
                        end else begin
                            oe_n_nxt = 1'b1;
                            st_nxt = SEERD_S_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt = SEERD_S_IDLE;
                end
            endcase
        end
    end

    // State registers.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= SEERD_S_IDLE;
            bit_r <= seerd_pkg::BIT_LAST;
            sh_r <= seerd_pkg::DATA_RESET;
            ptr_r <= seerd_pkg::ADDR_RESET;
            rd_r <= 1'b0;
            oe_n_r <= 1'b1;
            wpend_r <= 1'b0;
            wdat_r <= seerd_pkg::DATA_RESET;
            waddr_r <= seerd_pkg::ADDR_RESET;
            busy_r <= 8'h00;
            seen_r <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            rd_r <= rd_nxt;
            oe_n_r <= oe_n_nxt;
            wpend_r <= wpend_nxt;
            wdat_r <= wdat_nxt;
            waddr_r <= waddr_nxt;
            busy_r <= busy_nxt;
            seen_r <= seen_nxt;
        end
    end

    // Array write; only the last byte is kept, page buffering is not modelled.
    always_ff @(posedge ref_clk) begin
        if (clk_en && do_wr) begin
            mem[waddr_r] <= wdat_r;
        end
    end

    // Open drain: only ever pulls low.
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe_n = oe_n_r;
    assign prog_busy = (busy_r != 8'h00);
    assign addr_ptr = ptr_r;
endmodule : seerd_slave

// ### logic/seerd_master.sv
// Two-wire master end: runs reads and writes for its user.
`timescale 1ns/1ps
module seerd_master #(
    parameter int HALF = seerd_pkg::HALF_CYC
) (
    // System.
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Link.
    seerd_if.master bus,
    // Command in.
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire seerd_pkg::seerd_cmd_t cmd_op,
    input wire logic [seerd_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [seerd_pkg::DATA_W-1:0] cmd_wdata,
    input wire logic [7:0] cmd_len,
    // Read data out.
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [seerd_pkg::DATA_W-1:0] rd_data,
    // Status.
    output logic nack_err
);
    typedef enum logic [2:0] {
        SEERD_M_IDLE = 3'b000,
        SEERD_M_START = 3'b001,
        SEERD_M_BYTE = 3'b011,
        SEERD_M_ACK = 3'b010,
        SEERD_M_STOP = 3'b110,
        SEERD_M_HOLD = 3'b111
    } seerd_mst_t;
    localparam int DW = seerd_pkg::DATA_W;

    // Sampled data line.
    logic [1:0] sda_s_r;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sda_s_r <= 2'h3;
        end else if (clk_en) begin
            sda_s_r <= {sda_s_r[0], bus.sda};
        end
    end

    seerd_mst_t st_r, st_nxt;
    logic [7:0] div_r, div_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [DW-1:0] sh_r, sh_nxt;
    logic [2:0] step_r, step_nxt;
    logic [7:0] left_r, left_nxt;
    logic rx_r, rx_nxt, scl_r, scl_nxt, sda_r, sda_nxt, err_r, err_nxt;
    seerd_pkg::seerd_cmd_t op_r, op_nxt;
    logic [seerd_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [DW-1:0] wd_r, wd_nxt;
    // Two-entry read buffer.
    logic [DW-1:0] buf_r [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic wp_r, wp_nxt, rp_r, rp_nxt, push;
    logic tick;
    assign tick = (div_r == 8'(HALF - 1));

    function automatic logic [DW-1:0] ctrl(input logic [1:0] blk, input logic rw);
        ctrl = {seerd_pkg::DEV_CODE, 1'b0, blk, rw};
    endfunction : ctrl

    assign cmd_ready = (st_r == SEERD_M_IDLE);
    assign rd_valid = (cnt_r != 2'h0);
    assign rd_data = buf_r[rp_r];

    // Bit-level sequencing; phases: 0 clock low and data set, 1 clock high, 2 data sampled with clock still high.
    always_comb begin
        st_nxt = st_r; div_nxt = tick ? 8'h00 : div_r + 8'h01;
        ph_nxt = ph_r; bit_nxt = bit_r; sh_nxt = sh_r; step_nxt = step_r;
        left_nxt = left_r; rx_nxt = rx_r; scl_nxt = scl_r; sda_nxt = sda_r;
        err_nxt = err_r; op_nxt = op_r; addr_nxt = addr_r; wd_nxt = wd_r;
        push = 1'b0;
        case (st_r)
            SEERD_M_IDLE: begin
                div_nxt = 8'h00;
                if (cmd_valid) begin
                    op_nxt = cmd_op; addr_nxt = cmd_addr; wd_nxt = cmd_wdata;
                    left_nxt = cmd_len; err_nxt = 1'b0; step_nxt = 3'h0;
                    st_nxt = SEERD_M_START; ph_nxt = 2'h0;
                end
            end
            SEERD_M_START: if (tick) begin
                // Release, raise clock, then pull data low.
                ph_nxt = ph_r + 2'h1;
                if (ph_r == 2'h0) sda_nxt = 1'b1;
                if (ph_r == 2'h1) scl_nxt = 1'b1;
                if (ph_r == 2'h2) begin
                    sda_nxt = 1'b0; ph_nxt = 2'h0;
                    st_nxt = SEERD_M_BYTE; bit_nxt = seerd_pkg::BIT_LAST;
                    rx_nxt = 1'b0;
                    sh_nxt = (op_r != seerd_pkg::SEERD_CMD_CUR && step_r == 3'h0) ?
                        ctrl(addr_r[9:8], seerd_pkg::RW_WRITE) :
                        ctrl(addr_r[9:8], seerd_pkg::RW_READ);
                end
            end
            SEERD_M_BYTE, SEERD_M_ACK: if (tick) begin
                ph_nxt = (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
                if (ph_r == 2'h0) begin
                    scl_nxt = 1'b0;
                    sda_nxt = (st_r == SEERD_M_BYTE) ? (rx_r | sh_r[DW-1]) :
                        ~rx_r | (left_r == 8'h00);
                end
                if (ph_r == 2'h1) scl_nxt = 1'b1;
                if (ph_r == 2'h2) begin
                    if (st_r == SEERD_M_BYTE) begin
                        sh_nxt = {sh_r[DW-2:0], sda_s_r[1]};
                        bit_nxt = bit_r - 3'h1;
                        if (bit_r == seerd_pkg::BIT_FIRST) st_nxt = SEERD_M_ACK;
                    end else if (rx_r) begin
                        push = 1'b1;
                        if (left_r == 8'h00) st_nxt = SEERD_M_STOP;
                        else begin
                            left_nxt = left_r - 8'h01;
                            // Hold before a third byte could arrive with both entries full.
                            st_nxt = (cnt_r != 2'h0 && !(rd_valid && rd_ready)) ?
                                SEERD_M_HOLD : SEERD_M_BYTE;
                            bit_nxt = seerd_pkg::BIT_LAST;
                        end
                    end else if (sda_s_r[1]) begin
                        err_nxt = 1'b1; st_nxt = SEERD_M_STOP;
                    end else begin
                        step_nxt = step_r + 3'h1; bit_nxt = seerd_pkg::BIT_LAST;
                        st_nxt = SEERD_M_BYTE;
                        if (op_r == seerd_pkg::SEERD_CMD_CUR ||
                            (op_r == seerd_pkg::SEERD_CMD_RAND && step_r == 3'h2)) rx_nxt = 1'b1;
                        else if (step_r == 3'h0) sh_nxt = addr_r[7:0];
                        else if (op_r == seerd_pkg::SEERD_CMD_RAND) begin
                            st_nxt = SEERD_M_START; scl_nxt = 1'b0;
                        end else if (step_r == 3'h1) sh_nxt = wd_r;
                        else st_nxt = SEERD_M_STOP;
                    end
                end
            end
            SEERD_M_HOLD: begin
                // Buffer full: hold the clock high after the acknowledge until the user takes one entry.
                div_nxt = 8'h00;
                if (cnt_r != 2'h2) st_nxt = SEERD_M_BYTE;
            end
            SEERD_M_STOP: if (tick) begin
                ph_nxt = ph_r + 2'h1;
                if (ph_r == 2'h0) begin scl_nxt = 1'b0; sda_nxt = 1'b0; end
                if (ph_r == 2'h1) scl_nxt = 1'b1;
                if (ph_r == 2'h2) begin
                    sda_nxt = 1'b1; ph_nxt = 2'h0; st_nxt = SEERD_M_IDLE;
                end
            end
            default: st_nxt = SEERD_M_IDLE;
        endcase
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, rd_valid & rd_ready};
        wp_nxt = wp_r ^ push;
        rp_nxt = rp_r ^ (rd_valid & rd_ready);
    end

    // Registers.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= SEERD_M_IDLE; div_r <= 8'h00; ph_r <= 2'h0;
            bit_r <= seerd_pkg::BIT_LAST; sh_r <= seerd_pkg::DATA_RESET;
            step_r <= 3'h0; left_r <= 8'h00; rx_r <= 1'b0;
            scl_r <= 1'b1; sda_r <= 1'b1; err_r <= 1'b0;
            op_r <= seerd_pkg::SEERD_CMD_CUR; addr_r <= seerd_pkg::ADDR_RESET;
            wd_r <= seerd_pkg::DATA_RESET; cnt_r <= 2'h0; wp_r <= 1'b0; rp_r <= 1'b0;
            buf_r[0] <= seerd_pkg::DATA_RESET; buf_r[1] <= seerd_pkg::DATA_RESET;
        end else if (clk_en) begin
            st_r <= st_nxt; div_r <= div_nxt; ph_r <= ph_nxt; bit_r <= bit_nxt;
            sh_r <= sh_nxt; step_r <= step_nxt; left_r <= left_nxt; rx_r <= rx_nxt;
            scl_r <= scl_nxt; sda_r <= sda_nxt; err_r <= err_nxt; op_r <= op_nxt;
            addr_r <= addr_nxt; wd_r <= wd_nxt; cnt_r <= cnt_nxt;
            wp_r <= wp_nxt; rp_r <= rp_nxt;
            if (push) buf_r[wp_r] <= sh_r;
        end
    end

    assign bus.scl = scl_r;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe_n = sda_r;
    assign nack_err = err_r;
endmodule : seerd_master

// ### testbench/seerd_sva.sv
// Checker of the two-wire link between the master and the memory slave.
`timescale 1ns/1ps
module seerd_sva (
    // System.
    input wire logic ref_clk,
    input wire logic reset,
    // Link.
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic scl_r, sda_r, ctrl_r, rd_r, quiet_r, rise, start;
    logic ctrl_nxt, rd_nxt, quiet_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] byte_r, byte_nxt;
    assign rise = scl & ~scl_r;
    assign start = scl & scl_r & sda_r & ~sda;
    // Bit tracker; quiet marks a read ended by a missing master acknowledge.
    always_comb begin
        cnt_nxt = cnt_r;
        ctrl_nxt = ctrl_r;
        rd_nxt = rd_r;
        quiet_nxt = quiet_r;
        byte_nxt = byte_r;
        if (start) begin
            cnt_nxt = 4'h0;
            ctrl_nxt = 1'b1;
            rd_nxt = 1'b0;
            quiet_nxt = 1'b0;
        end else if (rise && cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            ctrl_nxt = 1'b0;
            rd_nxt = ctrl_r ? (byte_r[0] & ~sda) : rd_r;
            quiet_nxt = quiet_r | (~ctrl_r & rd_r & sda);
        end else if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
            byte_nxt = {byte_r[6:0], sda};
        end
    end
    // The idle bus is high, so reset values match a quiet line.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            {ctrl_r, rd_r, quiet_r, cnt_r, byte_r} <= '0;
        end else begin
            scl_r <= scl;
            sda_r <= sda;
            {ctrl_r, rd_r, quiet_r, cnt_r, byte_r} <= {ctrl_nxt, rd_nxt, quiet_nxt, cnt_nxt, byte_nxt};
        end
    end
    a_slave_moves_low: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("slave data changed while clock high");
    a_start_by_master: assert property ($fell(sda) && scl && $past(scl) |-> !sda_m_oe_n)
        else $error("start not made by master");
    a_stop_not_slave: assert property ($rose(sda) && scl && $past(scl) |-> $past(sda_s_oe_n))
        else $error("stop while slave held data");
    a_ctrl_byte_fields: assert property (rise && ctrl_r && cnt_r == 4'h8
        |-> byte_r[7:4] == seerd_pkg::DEV_CODE && !byte_r[3])
        else $error("control byte fields wrong");
    a_ctrl_slave_quiet: assert property (rise && ctrl_r && cnt_r < 4'h8 |-> sda_s_oe_n)
        else $error("slave drove during control byte");
    a_nack_line_free: assert property (quiet_r |-> sda_s_oe_n)
        else $error("slave drove after missing acknowledge");
    a_ack_slot_free: assert property (rise && rd_r && !ctrl_r && cnt_r == 4'h8 |-> sda_s_oe_n)
        else $error("slave drove in master acknowledge slot");
    a_read_master_off: assert property (rise && rd_r && !ctrl_r && !quiet_r && cnt_r < 4'h8
        |-> sda_m_oe_n)
        else $error("master drove during read data");
    c_read_acked: cover property (rise && ctrl_r && cnt_r == 4'h8 && byte_r[0] && !sda);
    c_master_ack: cover property (rise && rd_r && !ctrl_r && cnt_r == 4'h8 && !sda);
    c_read_ended: cover property ($rose(quiet_r));
endmodule : seerd_sva

// ### testbench/serial_eeprom_read_path_tb.sv
// Testbench joining master and slave ends over the two-wire link.
`timescale 1ns/1ps
module serial_eeprom_read_path_tb;
    logic ref_clk, reset, write_protect, cmd_valid, rd_ready, stall;
    logic cmd_ready, rd_valid, nack_err, prog_busy;
    seerd_pkg::seerd_cmd_t cmd_op;
    logic [9:0] cmd_addr, addr_ptr, ptr_m, r;
    logic [7:0] cmd_wdata, cmd_len, rd_data;
    logic [7:0] mem_m [1024];
    logic [7:0] exp_q [$];
    logic [9:0] wa [11];
    logic [31:0] seed = 32'h0000_d0fb;
    logic [31:0] s;
    int mismatches = 0, comparisons = 0, cycles = 0;
    seerd_if u_seerd_if ();
    seerd_master u_seerd_master (.ref_clk, .reset, .clk_en(1'b1), .bus(u_seerd_if), .cmd_valid,
        .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_len, .rd_valid, .rd_ready, .rd_data,
        .nack_err);
    seerd_slave u_seerd_slave (.ref_clk, .reset, .clk_en(1'b1), .bus(u_seerd_if),
        .write_protect, .prog_busy, .addr_ptr);
    seerd_sva u_seerd_sva (.ref_clk, .reset, .scl(u_seerd_if.scl), .sda(u_seerd_if.sda),
        .sda_m_oe_n(u_seerd_if.sda_m_oe_n), .sda_s_oe_n(u_seerd_if.sda_s_oe_n));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task tally_and_finish();
        if (mismatches == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // Holds the command until it is taken, then waits for the master to go idle.
    task run_cmd(input seerd_pkg::seerd_cmd_t op, input logic [9:0] a, input logic [7:0] d,
        input logic [7:0] n);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_len = n;
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        while (cmd_ready !== 1'b1) @(posedge ref_clk);
        #1 cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1) @(posedge ref_clk);
        #1;
    endtask : run_cmd
    // The busy flag is sampled late because the slave sees the stop a few cycles after it.
    task wr(input logic [9:0] a, input logic [7:0] d);
        int k;
        run_cmd(seerd_pkg::SEERD_CMD_WRITE, a, d, 8'h00);
        if (!write_protect) mem_m[a] = d;
        ptr_m = a + 10'h001;
        for (k = 0; k < 16 && prog_busy !== 1'b1; k++) @(posedge ref_clk);
        check("prog_busy", 16'(!write_protect), 16'(k < 16));
        while (prog_busy !== 1'b0) @(posedge ref_clk);
        #1;
        if (!write_protect) check("addr_ptr", 16'(ptr_m), 16'(addr_ptr));
    endtask : wr
    task rd(input seerd_pkg::seerd_cmd_t op, input logic [9:0] a, input logic [7:0] n);
        if (op == seerd_pkg::SEERD_CMD_RAND) ptr_m = a;
        // The block select bits of a current read replace the upper pointer bits.
        if (op == seerd_pkg::SEERD_CMD_CUR) ptr_m[9:8] = a[9:8];
        for (int i = 0; i <= n; i++) begin
            exp_q.push_back(mem_m[ptr_m]);
            ptr_m++;
        end
        run_cmd(op, a, 8'h00, n);
        check("nack_err", 16'h0000, 16'(nack_err));
        check("addr_ptr", 16'(ptr_m), 16'(addr_ptr));
    endtask : rd
    // Receiver stalls at random, or fully while stall is set.
    always @(posedge ref_clk) begin
        #1;
        rd_ready = !stall && (rnd() & 32'h0000_0003) != 32'h0000_0000;
    end
    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            check("rd_data", exp_q.size() > 0 ? 16'(exp_q.pop_front()) : 16'hffff,
                16'(rd_data));
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        {reset, stall} = 2'b11;
        {write_protect, cmd_valid, rd_ready} = 3'b000;
        cmd_op = seerd_pkg::SEERD_CMD_WRITE;
        {cmd_addr, cmd_wdata, cmd_len, ptr_m} = '0;
        repeat (3) @(posedge ref_clk);
        #1 {reset, stall} = 2'b00;
        s = rnd();
        r = {s[9:8], 2'b01, s[5:0]};
        wa = '{10'h3fe, 10'h3ff, 10'h000, 10'h001, 10'h002, 10'h080, 10'h180, 10'h280,
            10'h380, r, r + 10'h001};
        for (int i = 0; i < 11; i++) begin
            s = rnd();
            wr(wa[i], s[7:0]);
        end
        rd(seerd_pkg::SEERD_CMD_RAND, 10'h3fe, 8'h03);
        rd(seerd_pkg::SEERD_CMD_CUR, 10'h000, 8'h00);
        for (int b = 0; b < 4; b++) rd(seerd_pkg::SEERD_CMD_RAND, {2'(b), 8'h80}, 8'h00);
        rd(seerd_pkg::SEERD_CMD_RAND, r, 8'h00);
        rd(seerd_pkg::SEERD_CMD_CUR, r + 10'h001, 8'h00);
        write_protect = 1'b1;
        wr(10'h3fe, ~mem_m[10'h3fe]);
        write_protect = 1'b0;
        rd(seerd_pkg::SEERD_CMD_RAND, 10'h3fe, 8'h00);
        // A full buffer must park the clock high after an acknowledge rather than drop a byte.
        stall = 1'b1;
        fork
            rd(seerd_pkg::SEERD_CMD_RAND, 10'h3ff, 8'h03);
            begin
                repeat (1000) @(posedge ref_clk);
                check("scl", 16'h0001, 16'(u_seerd_if.scl));
                stall = 1'b0;
            end
        join
        while (exp_q.size() != 0) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule : serial_eeprom_read_path_tb
